// [nvss_defines.svh]
// Purpose: timing counts and fixed addresses for the memory controller
// Assumes: sys_clk at 100 MHz, 10 ns period
// Notes: cycle counts derive from times in their own unit
`ifndef NVSS_DEFINES_SVH
`define NVSS_DEFINES_SVH
`define NVSS_CLK_PERIOD_NS 10
`define NVSS_ADDR_W 13
`define NVSS_DATA_W 8
// least times, rounded up to whole cycles
`define NVSS_CYCLE_NS 55
`define NVSS_CYCLE_CYC ((`NVSS_CYCLE_NS + `NVSS_CLK_PERIOD_NS - 1) / `NVSS_CLK_PERIOD_NS)
`define NVSS_PULSE_NS 45
`define NVSS_PULSE_CYC ((`NVSS_PULSE_NS + `NVSS_CLK_PERIOD_NS - 1) / `NVSS_CLK_PERIOD_NS)
// busy waits after a save or restore sequence, and the power-up wait
`define NVSS_SAVE_MS 10
`define NVSS_SAVE_CYC (`NVSS_SAVE_MS * 1000000 / `NVSS_CLK_PERIOD_NS)
`define NVSS_RESTORE_US 20
`define NVSS_RESTORE_CYC (`NVSS_RESTORE_US * 1000 / `NVSS_CLK_PERIOD_NS)
`define NVSS_PWRUP_US 550
`define NVSS_PWRUP_CYC (`NVSS_PWRUP_US * 1000 / `NVSS_CLK_PERIOD_NS)
// sequence addresses
`define NVSS_SEQ0 13'h0000
`define NVSS_SEQ1 13'h1555
`define NVSS_SEQ2 13'h0aaa
`define NVSS_SEQ3 13'h1fff
`define NVSS_SEQ4 13'h10f0
`define NVSS_SEQ_SAVE 13'h0f0f
`define NVSS_SEQ_RESTORE 13'h0f0e
`endif

// [nvss_pkg.sv]
// Purpose: types for the memory controller
// Assumes: nothing
// Notes: commands from the user side
package nvss_pkg;
	typedef enum logic [1:0] {
		NVSS_CMD_READ,
		NVSS_CMD_WRITE,
		NVSS_CMD_SAVE,
		NVSS_CMD_RESTORE
	} nvss_cmd_t;
endpackage

// [nvss_timer.sv]
// Purpose: loadable down counter for waits
// Assumes: load and count never overlap usefully
// Notes: done is a level while the count is zero
`include "nvss_defines.svh"
module nvss_timer (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// control
	input wire logic load,
	input wire logic [23:0] load_val,
	// status
	output logic done
);
	logic [23:0] cnt_q;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cnt_q <= 24'h000000;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != 24'h000000) begin
			cnt_q <= cnt_q - 24'h000001;
		end
	end

	assign done = (cnt_q == 24'h000000);
endmodule // nvss_timer

// [nvss_host.sv]
// What this block does
// - address steady across whole write
// - drive pin high throughout every write
// - six reads 0000..0f0f start save
// - six reads 0000..0f0e start restore
// - steps are select controlled reads
// - strobe high through all six steps
// - no write held as restore ends
//
// Purpose: host controller driving the memory pins
// Assumes: pins of the memory sit in the sys_clk domain via pads
// Notes: one access at a time; no pin reads the memory's state back
`include "nvss_defines.svh"
module nvss_host #(
	parameter int unsigned SAVE_CYC = `NVSS_SAVE_CYC,
	parameter int unsigned RESTORE_CYC = `NVSS_RESTORE_CYC,
	parameter int unsigned PWRUP_CYC = `NVSS_PWRUP_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// user command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [12:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic busy,
	// memory pins
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_drive_n,
	output logic [12:0] byte_select_lines,
	input wire logic [7:0] bidir_byte_pins_i,
	output logic [7:0] bidir_byte_pins_o,
	output logic bidir_byte_pins_oe
);
	typedef enum logic [2:0] {
		NVSS_ST_PWRUP, NVSS_ST_IDLE, NVSS_ST_SETUP, NVSS_ST_PULSE,
		NVSS_ST_GAP, NVSS_ST_WAIT
	} nvss_state_t;

	nvss_state_t st_q;
	logic [1:0] op_q;
	logic [2:0] step_q;
	logic [7:0] sync1_q, sync2_q;
	logic t_load, t_done;
	logic [23:0] t_val;
	logic pw_armed_q;

	// pin data passes two flops before use
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
		end else begin
			sync1_q <= bidir_byte_pins_i;
			sync2_q <= sync1_q;
		end
	end

	nvss_timer i_nvss_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.load(t_load),
		.load_val(t_val),
		.done(t_done)
	);

	function automatic logic [12:0] seq_addr(input logic [2:0] s,
		input logic sv);
		case (s)
			3'h0: seq_addr = `NVSS_SEQ0;
			3'h1: seq_addr = `NVSS_SEQ1;
			3'h2: seq_addr = `NVSS_SEQ2;
			3'h3: seq_addr = `NVSS_SEQ3;
			3'h4: seq_addr = `NVSS_SEQ4;
			default: seq_addr = sv ? `NVSS_SEQ_SAVE : `NVSS_SEQ_RESTORE;
		endcase
	endfunction

	logic is_seq, is_wr;
	assign is_seq = (op_q == 2'(nvss_pkg::NVSS_CMD_SAVE)) ||
		(op_q == 2'(nvss_pkg::NVSS_CMD_RESTORE));
	assign is_wr = (op_q == 2'(nvss_pkg::NVSS_CMD_WRITE));
	assign cmd_ready = (st_q == NVSS_ST_IDLE);
	assign busy = (st_q == NVSS_ST_WAIT) || (st_q == NVSS_ST_PWRUP);

	// timer loads: pulse width, gap, or long busy waits
	always_comb begin
		t_load = 1'b0;
		t_val = 24'h000000;
		case (st_q)
			NVSS_ST_PWRUP: begin
				t_load = !pw_armed_q;
				t_val = 24'(PWRUP_CYC);
			end
			NVSS_ST_SETUP: begin
				t_load = 1'b1;
				t_val = 24'(`NVSS_PULSE_CYC);
			end
			NVSS_ST_PULSE: begin
				if (t_done) begin
					t_load = 1'b1;
					if (is_seq && step_q == 3'h5) begin
						t_val = (op_q == 2'(nvss_pkg::NVSS_CMD_SAVE)) ?
							24'(SAVE_CYC) : 24'(RESTORE_CYC);
					end else begin
						t_val = 24'(`NVSS_CYCLE_CYC - `NVSS_PULSE_CYC + 1);
					end
				end
			end
			default: begin
				t_load = 1'b0;
			end
		endcase
	end

	// main sequencer
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_q <= NVSS_ST_PWRUP;
			op_q <= 2'h0;
			step_q <= 3'h0;
		end else begin
			case (st_q)
				NVSS_ST_PWRUP: begin
					// wait for power-up restore
					// timer idles at zero, so wait until it was loaded
					if (pw_armed_q && t_done) begin
						st_q <= NVSS_ST_IDLE;
					end
				end
				NVSS_ST_IDLE: begin
					if (cmd_valid) begin
						op_q <= cmd_op;
						step_q <= 3'h0;
						st_q <= NVSS_ST_SETUP;
					end
				end
				NVSS_ST_SETUP: begin
					st_q <= NVSS_ST_PULSE;
				end
				NVSS_ST_PULSE: begin
					if (t_done) begin
						st_q <= (is_seq && step_q == 3'h5) ?
							NVSS_ST_WAIT : NVSS_ST_GAP;
					end
				end
				NVSS_ST_GAP: begin
					// steps spaced by the gap wait that fills out the cycle time
					if (t_done) begin
						if (is_seq && step_q != 3'h5) begin
							step_q <= step_q + 3'h1;
							st_q <= NVSS_ST_SETUP;
						end else begin
							st_q <= NVSS_ST_IDLE;
						end
					end
				end
				NVSS_ST_WAIT: begin
					if (t_done) begin
						st_q <= NVSS_ST_IDLE;
					end
				end
				default: begin
					st_q <= NVSS_ST_IDLE;
				end
			endcase
		end
	end

	// pins: address set in setup, held until select rises
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			byte_select_lines <= 13'h0000;
			bidir_byte_pins_o <= 8'h00;
		end else if (st_q == NVSS_ST_IDLE && cmd_valid) begin
			byte_select_lines <= (cmd_op[1]) ? `NVSS_SEQ0 : cmd_addr;
			bidir_byte_pins_o <= cmd_wdata;
		end else if (st_q == NVSS_ST_GAP && t_done && is_seq &&
			step_q != 3'h5) begin
			byte_select_lines <= seq_addr(step_q + 3'h1,
				op_q == 2'(nvss_pkg::NVSS_CMD_SAVE));
		end
	end

	assign chip_select_n = !(st_q == NVSS_ST_PULSE);
	// strobe only for writes; high in sequences; high idle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			write_strobe_n <= 1'b1;
		end else begin
			// low through the pulse, rises a cycle after select
			write_strobe_n <= !(is_wr &&
				(st_q == NVSS_ST_SETUP || st_q == NVSS_ST_PULSE));
		end
	end
	// drive pin high in writes; low for plain reads
	assign output_drive_n = !(st_q == NVSS_ST_PULSE &&
		op_q == 2'(nvss_pkg::NVSS_CMD_READ));
	assign bidir_byte_pins_oe = is_wr &&
		(st_q == NVSS_ST_SETUP || st_q == NVSS_ST_PULSE ||
		st_q == NVSS_ST_GAP);

	// read data sampled at pulse end, after sync delay
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
		end else begin
			rsp_valid <= st_q == NVSS_ST_PULSE && t_done &&
				op_q == 2'(nvss_pkg::NVSS_CMD_READ);
			if (st_q == NVSS_ST_PULSE && t_done &&
				op_q == 2'(nvss_pkg::NVSS_CMD_READ)) begin
				rsp_rdata <= sync2_q;
			end
		end
	end

	// power-up wait loaded once, right after reset
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pw_armed_q <= 1'b0;
		end else begin
			pw_armed_q <= 1'b1;
		end
	end

	// select low only in pulse state
	property p_sel_pulse;
		@(posedge sys_clk) disable iff (!nrst)
		!chip_select_n |-> st_q == NVSS_ST_PULSE;
	endproperty
	a_sel_pulse: assert property (p_sel_pulse) else $error("select out");

	property p_seq_ws;
		@(posedge sys_clk) disable iff (!nrst)
		is_seq && st_q != NVSS_ST_IDLE |-> write_strobe_n;
	endproperty
	a_seq_ws: assert property (p_seq_ws) else $error("strobe in seq");

	// drive pin high while strobe low
	property p_wr_oe;
		@(posedge sys_clk) disable iff (!nrst)
		!write_strobe_n |-> output_drive_n;
	endproperty
	a_wr_oe: assert property (p_wr_oe) else $error("drive in write");

	property p_addr_hold;
		@(posedge sys_clk) disable iff (!nrst)
		!chip_select_n && $past(!chip_select_n) |->
			$stable(byte_select_lines);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("addr moved");

	property p_busy;
		@(posedge sys_clk) disable iff (!nrst)
		busy |-> chip_select_n && !cmd_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("busy access");

	// no write as power-up restore ends
	property p_pwr;
		@(posedge sys_clk) disable iff (!nrst)
		st_q == NVSS_ST_PWRUP |-> write_strobe_n && chip_select_n;
	endproperty
	a_pwr: assert property (p_pwr) else $error("write at pwrup");

	property p_step0;
		@(posedge sys_clk) disable iff (!nrst)
		is_seq && step_q == 3'h0 && !chip_select_n |->
			byte_select_lines == 13'h0000;
	endproperty
	a_step0: assert property (p_step0) else $error("bad step0");

	// host data driven only for writes
	property p_oe;
		@(posedge sys_clk) disable iff (!nrst)
		bidir_byte_pins_oe |-> is_wr && output_drive_n;
	endproperty
	a_oe: assert property (p_oe) else $error("bus clash");
endmodule // nvss_host

// [nvss_mem_model.sv]
// Purpose: behavioural memory with a shadow array, seen from the host
// Assumes: the bench resolves the shared data lines
// Notes: undriven lines show the inverse of the last byte driven
`include "nvss_defines.svh"
module nvss_mem_model #(
	parameter int SAVE_NS = 150,
	parameter int RESTORE_NS = 150,
	parameter int PWRUP_NS = 150
) (
	// memory pins
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_drive_n,
	input wire logic [12:0] byte_select_lines,
	input wire logic [7:0] bidir_byte_pins,
	output logic [7:0] dev_byte,
	output logic dev_oe,
	// supply state
	input wire logic supply_low
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [12:0] SEQ [0:4] = '{`NVSS_SEQ0, `NVSS_SEQ1,
		`NVSS_SEQ2, `NVSS_SEQ3, `NVSS_SEQ4};
	logic [7:0] mem [0:8191];
	logic [7:0] nv [0:8191];
	logic [7:0] last;
	logic [7:0] wdat;
	logic [12:0] aq;
	logic deaf;
	logic [2:0] step;
	initial begin
		deaf = 1'b1;
		step = 3'h0;
		last = 8'h00;
		for (int i = 0; i < 8192; i++) begin
			nv[i] = i[7:0] ^ 8'h5a;
			mem[i] = 8'h00;
		end
		#PWRUP_NS;
		mem = nv;
		deaf = 1'b0;
	end
	assign dev_oe = !deaf && !chip_select_n && !output_drive_n && write_strobe_n;
	always @* begin
		if (dev_oe) begin
			dev_byte = mem[byte_select_lines];
			last = dev_byte;
		end else
			dev_byte = ~last;
	end
	// address taken as select falls
	always @(negedge chip_select_n)
		aq = byte_select_lines;
	// data tracked while the write is open, hold may be zero
	always @* if (!chip_select_n && !write_strobe_n) wdat = bidir_byte_pins;
	always @(posedge write_strobe_n)
		if (!deaf && !chip_select_n) mem[aq] = wdat;
	always @(posedge chip_select_n) begin
		if (deaf) begin
		end else if (!write_strobe_n) begin
			mem[aq] = wdat;
			step = 3'h0;
		end else if (step == 3'h5) begin
			step = 3'h0;
			// deaf, erase, program; no save at low supply
			if (aq == `NVSS_SEQ_SAVE && !supply_low) begin
				deaf = 1'b1;
				for (int i = 0; i < 8192; i++) nv[i] = 8'hff;
				nv = mem;
				#SAVE_NS;
				deaf = 1'b0;
			end else if (aq == `NVSS_SEQ_RESTORE) begin
				deaf = 1'b1;
				for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
				mem = nv;
				#RESTORE_NS;
				deaf = 1'b0;
			end
		end else
			step = (aq == SEQ[step]) ? step + 3'h1 : {2'b00, aq == 13'h0000};
	end
endmodule // nvss_mem_model

// [nvss_host_tb_top.sv]
// Purpose: self-checking bench for the memory host controller
// Assumes: waits shortened to 20 cycles, model durations inside them
// Notes: expected bytes kept in a shadow of the memory in the bench
module nvss_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic nrst, cmd_valid, cmd_ready, rsp_valid, busy, supply_low;
	logic cs_n, ws_n, od_n, host_oe, dev_oe;
	logic [1:0] cmd_op;
	logic [12:0] cmd_addr, lines;
	logic [7:0] cmd_wdata, rsp_rdata, host_byte, dev_byte, pins;
	logic [7:0] exp_mem [0:8191];
	logic [7:0] exp_nv [0:8191];
	logic [7:0] exp_q [$];
	int fails = 0;
	int num_checks = 0;
	int seed = 32'h9b001fa3;
	always #5 sys_clk = ~sys_clk;
	assign pins = host_oe ? host_byte : dev_byte;
	nvss_host #(.SAVE_CYC(20), .RESTORE_CYC(20), .PWRUP_CYC(20)) i_nvss_host (
		.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.busy(busy), .chip_select_n(cs_n), .write_strobe_n(ws_n),
		.output_drive_n(od_n), .byte_select_lines(lines),
		.bidir_byte_pins_i(pins), .bidir_byte_pins_o(host_byte),
		.bidir_byte_pins_oe(host_oe));
	nvss_mem_model i_nvss_mem_model (
		.chip_select_n(cs_n), .write_strobe_n(ws_n), .output_drive_n(od_n),
		.byte_select_lines(lines), .bidir_byte_pins(pins),
		.dev_byte(dev_byte), .dev_oe(dev_oe), .supply_low(supply_low));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [1:0] op, input logic [12:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		cmd_wdata = d;
		while (cmd_ready !== 1'b1 && n < 5000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 5000) fails++;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		exp_mem[a] = d;
		cmd(2'h1, a, d);
	endtask
	task automatic rd(input logic [12:0] a);
		exp_q.push_back(exp_mem[a]);
		cmd(2'h0, a, 8'h00);
	endtask
	task automatic seq(input logic save);
		cmd(save ? 2'h2 : 2'h3, 13'h0000, 8'h00);
		if (save && !supply_low) exp_nv = exp_mem;
		if (!save) exp_mem = exp_nv;
		// supply state must hold until the sixth step is done
		while (cmd_ready !== 1'b1) @(negedge sys_clk);
	endtask
	// results compared oldest first
	always @(negedge sys_clk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() != 0)
				check(rsp_rdata, exp_q.pop_front());
			else
				check(8'hff, 8'h00);
		end
		if (host_oe === 1'b1) check({7'h00, dev_oe}, 8'h00);
		if (busy === 1'b1) check({7'h00, cs_n}, 8'h01);
	end
	initial begin
		logic [12:0] a;
		logic [7:0] d;
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_addr = 13'h0000;
		cmd_wdata = 8'h00;
		supply_low = 1'b0;
		for (int i = 0; i < 8192; i++) exp_nv[i] = i[7:0] ^ 8'h5a;
		exp_mem = exp_nv;
		repeat (10) @(negedge sys_clk);
		nrst = 1'b1;
		@(negedge sys_clk);
		check({7'h00, busy}, 8'h01);
		rd(13'h0000);
		rd(13'h1fff);
		rd(13'h0aaa);
		for (int k = 0; k < 12; k++) begin
			a = 13'($random(seed));
			d = 8'($random(seed));
			wr(a, d);
			rd(a);
		end
		wr(13'h0000, 8'h3c);
		wr(13'h1fff, 8'hc3);
		seq(1'b1);
		wr(13'h0000, 8'h11);
		wr(13'h1fff, 8'h22);
		rd(13'h0000);
		seq(1'b0);
		rd(13'h0000);
		rd(13'h1fff);
		supply_low = 1'b1;
		wr(13'h0000, 8'h77);
		seq(1'b1);
		supply_low = 1'b0;
		seq(1'b0);
		rd(13'h0000);
		repeat (20) @(negedge sys_clk);
		check(8'(exp_q.size()), 8'h00);
		close_out();
	end
	// cut a hang short
	initial begin
		#300000;
		fails++;
		close_out();
	end
endmodule // nvss_host_tb_top
